// ==== rtl/spi_status_flags_defs.vh ====
// constants for the serial link status block
// assumes a 32-bit apb master and an external serial controller on the link
`ifndef SPI_STATUS_FLAGS_DEFS_VH
`define SPI_STATUS_FLAGS_DEFS_VH

// register byte offsets
`define OFS_STATUS        8'h00
`define OFS_CONTROL       8'h04
`define OFS_DATA          8'h08
`define OFS_INT_STATUS    8'h0c
`define OFS_INT_MASK      8'h10

// status field positions
`define ST_RX_FILL_HI     28
`define ST_RX_FILL_LO     24
`define ST_TX_FILL_HI     20
`define ST_TX_FILL_LO     16
`define ST_FRAME_ERR      12
`define ST_ACTIVE         11
`define ST_TX_UNDERRUN    8
`define ST_SHIFTER_EMPTY  7
`define ST_RX_OVERFLOW    6
`define ST_RX_EMPTY       5
`define ST_TX_EMPTY       3
`define ST_TX_FULL        1
`define ST_RX_FULL        0

// control field positions
`define CT_MODULE_ON      0
`define CT_ENH_BUF        1
`define CT_FRAMED         2

// interrupt event positions
`define EV_RX_WORD        0
`define EV_RX_OVERFLOW    1
`define EV_TX_UNDERRUN    2
`define EV_FRAME_ERR      3
`define EV_WIDTH          4

// reset values
`define CONTROL_RESET     3'h0
`define INT_MASK_RESET    4'h0

// buffer geometry
`define FIFO_DEPTH        5'h10
`define LEGACY_DEPTH      5'h01
`define WORD_BITS         4'h8

`endif

// ==== rtl/spi_status_flags.v ====
// serial link unit with its status register, buffers, apb slave and interrupt
// assumes sck, ss_n and mosi come from an external controller, asynchronous to pclk
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "spi_status_flags_defs.vh"

module spi_status_flags (
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata_q,
   output reg         pready_q,
   output reg         pslverr_q,
   // serial link
   input  wire        sck,
   input  wire        ss_n,
   input  wire        mosi,
   output reg         miso_q,
   // interrupt
   output reg         irq_q
);

   // apb access completes at the edge where pready is seen high
   wire        acc       = psel & penable & pready_q;
   wire        wr_acc    = acc & pwrite;
   wire        rd_acc    = acc & ~pwrite;

   // control
   reg  [2:0]  control_q;
   reg         on_prev_q;
   reg  [`EV_WIDTH-1:0] int_status_q;
   reg  [`EV_WIDTH-1:0] int_mask_q;
   wire        module_on = control_q[`CT_MODULE_ON];
   wire        enh       = control_q[`CT_ENH_BUF];
   wire        framed    = control_q[`CT_FRAMED];
   wire        reenable  = module_on & ~on_prev_q;

   // sticky flags
   reg         frame_error_flag_q;
   reg         tx_underrun_flag_q;
   reg         rx_overflow_flag_q;

   // fifos
   reg  [7:0]  tx_mem [0:15];
   reg  [7:0]  rx_mem [0:15];
   reg  [4:0]  tx_wr_q;
   reg  [4:0]  tx_rd_q;
   reg  [4:0]  fifo_write_pointer_q;
   reg  [4:0]  fifo_read_pointer_q;
   wire [4:0]  limit     = enh ? `FIFO_DEPTH : `LEGACY_DEPTH;
   wire [4:0]  tx_fill_count = tx_wr_q - tx_rd_q;
   wire [4:0]  rx_fill_count = fifo_write_pointer_q - fifo_read_pointer_q;
   wire        tx_empty  = (tx_wr_q == tx_rd_q);
   wire        rx_empty  = (fifo_write_pointer_q == fifo_read_pointer_q);
   wire        tx_full   = (tx_fill_count >= limit);
   wire        rx_full   = (rx_fill_count >= limit);

   // link synchronisers, stage one read only by stage two
   reg  [2:0]  sck_s_q;
   reg  [1:0]  ss_s_q;
   reg  [1:0]  mosi_s_q;
   reg         ss_prev_q;
   wire        sck_rise  = sck_s_q[1] & ~sck_s_q[2];
   wire        sck_fall  = ~sck_s_q[1] & sck_s_q[2];
   wire        sel       = ~ss_s_q[1];
   wire        frame_go  = sel & ss_prev_q;
   wire        frame_end = ~sel & ~ss_prev_q;

   // shifter
   reg  [7:0]  tx_shift_q;
   reg  [7:0]  rx_shift_q;
   reg  [3:0]  bit_cnt_q;
   reg         shifter_loaded_q;
   wire [7:0]  rx_next   = {rx_shift_q[6:0], mosi_s_q[1]};
   wire        word_done = module_on & sel & sck_rise & (bit_cnt_q == `WORD_BITS - 4'h1);
   // next word loads at frame start and right after each word, before the next rising edge
   wire        load_now  = module_on & (frame_go | word_done);
   wire        underrun  = load_now & tx_empty & framed;
   // select released mid-word is a broken frame
   wire        frame_bad = module_on & framed & frame_end & (bit_cnt_q != 4'h0);
   wire        ovf_now   = word_done & rx_full;
   wire        rx_push   = word_done & ~rx_full;
   wire        tx_pop    = load_now & ~tx_empty;

   wire        dec_status = (paddr == `OFS_STATUS);
   wire        dec_ctrl   = (paddr == `OFS_CONTROL);
   wire        dec_data   = (paddr == `OFS_DATA);
   wire        dec_ist    = (paddr == `OFS_INT_STATUS);
   wire        dec_imask  = (paddr == `OFS_INT_MASK);
   wire        mapped     = dec_status | dec_ctrl | dec_data | dec_ist | dec_imask;
   wire        tx_push    = wr_acc & dec_data & module_on & ~tx_full;
   wire        rx_pop     = rd_acc & dec_data & ~rx_empty;
   wire        wr_status  = wr_acc & dec_status;

   wire [`EV_WIDTH-1:0] events;
   assign events[`EV_RX_WORD]     = rx_push;
   assign events[`EV_RX_OVERFLOW] = ovf_now;
   assign events[`EV_TX_UNDERRUN] = underrun;
   assign events[`EV_FRAME_ERR]   = frame_bad;

   // status word, unlisted bits stay zero
   reg  [31:0] status_word;
   always @* begin
      status_word = 32'h0000_0000;
      status_word[`ST_RX_FILL_HI:`ST_RX_FILL_LO] = enh ? rx_fill_count : 5'h00;
      status_word[`ST_TX_FILL_HI:`ST_TX_FILL_LO] = enh ? tx_fill_count : 5'h00;
      status_word[`ST_FRAME_ERR]     = frame_error_flag_q;
      status_word[`ST_ACTIVE]        = module_on & (sel | shifter_loaded_q | ~tx_empty);
      status_word[`ST_TX_UNDERRUN]   = tx_underrun_flag_q;
      status_word[`ST_SHIFTER_EMPTY] = enh & ~shifter_loaded_q;
      status_word[`ST_RX_OVERFLOW]   = rx_overflow_flag_q;
      status_word[`ST_RX_EMPTY]      = enh & rx_empty;
      status_word[`ST_TX_EMPTY]      = tx_empty;
      status_word[`ST_TX_FULL]       = tx_full;
      status_word[`ST_RX_FULL]       = rx_full;
   end

   reg  [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h0000_0000;
      case (1'b1)
         dec_status: rd_mux = status_word;
         dec_ctrl:   rd_mux = {29'h0, control_q};
         dec_data:   rd_mux = rx_empty ? 32'h0000_0000 : {24'h00_0000, rx_mem[fifo_read_pointer_q[3:0]]};
         dec_ist:    rd_mux = {28'h000_0000, int_status_q};
         dec_imask:  rd_mux = {28'h000_0000, int_mask_q};
         default:    rd_mux = 32'h0000_0000;
      endcase
   end

   // next interrupt state; a new event wins over the read clear
   reg  [`EV_WIDTH-1:0] int_status_d;
   reg  [`EV_WIDTH-1:0] int_mask_d;
   always @* begin
      int_status_d = int_status_q | events;
      if (rd_acc & dec_ist)
         int_status_d = (int_status_q & ~prdata_q[`EV_WIDTH-1:0]) | events;
      int_mask_d = int_mask_q;
      if (wr_acc & dec_imask)
         int_mask_d = pwdata[`EV_WIDTH-1:0];
   end

   // apb handshake: one wait cycle, data captured before the completing edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= psel & penable & ~pready_q;
         if (psel & penable & ~pready_q) begin
            prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_q <= ~mapped;
         end else begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
         end
      end
   end

   // control, mask and interrupt status; a set wins over a read clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_q    <= `CONTROL_RESET;
         on_prev_q    <= 1'b0;
         int_mask_q   <= `INT_MASK_RESET;
         int_status_q <= {`EV_WIDTH{1'b0}};
         irq_q        <= 1'b0;
      end else begin
         on_prev_q <= module_on;
         if (wr_acc & dec_ctrl)
            control_q <= pwdata[2:0];
         int_mask_q   <= int_mask_d;
         int_status_q <= int_status_d;
         // irq follows the next status and mask, so a read clear drops it at once
         irq_q        <= |(int_status_d & int_mask_d);
      end
   end

   // sticky error flags; hardware set wins over software or re-enable clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_error_flag_q <= 1'b0;
         tx_underrun_flag_q <= 1'b0;
         rx_overflow_flag_q <= 1'b0;
      end else begin
         if (frame_bad)
            frame_error_flag_q <= 1'b1;
         else if (wr_status & ~pwdata[`ST_FRAME_ERR])
            frame_error_flag_q <= 1'b0;
         if (underrun)
            tx_underrun_flag_q <= 1'b1;
         else if (reenable | (wr_status & ~pwdata[`ST_TX_UNDERRUN]))
            tx_underrun_flag_q <= 1'b0;
         if (ovf_now)
            rx_overflow_flag_q <= 1'b1;
         else if (reenable | (wr_status & ~pwdata[`ST_RX_OVERFLOW]))
            rx_overflow_flag_q <= 1'b0;
      end
   end

   // fifo storage; pointers carry a wrap bit so full and empty differ
   integer i;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (i = 0; i < 16; i = i + 1) begin
            tx_mem[i] <= 8'h00;
            rx_mem[i] <= 8'h00;
         end
      end else begin
         if (tx_push)
            tx_mem[tx_wr_q[3:0]] <= pwdata[7:0];
         if (rx_push)
            rx_mem[fifo_write_pointer_q[3:0]] <= rx_next;
      end
   end

   // pointers flush while the module is off
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_wr_q              <= 5'h00;
         tx_rd_q              <= 5'h00;
         fifo_write_pointer_q <= 5'h00;
         fifo_read_pointer_q  <= 5'h00;
      end else if (!module_on) begin
         tx_wr_q              <= 5'h00;
         tx_rd_q              <= 5'h00;
         fifo_write_pointer_q <= 5'h00;
         fifo_read_pointer_q  <= 5'h00;
      end else begin
         if (tx_push)
            tx_wr_q <= tx_wr_q + 5'h01;
         if (tx_pop)
            tx_rd_q <= tx_rd_q + 5'h01;
         if (rx_push)
            fifo_write_pointer_q <= fifo_write_pointer_q + 5'h01;
         if (rx_pop)
            fifo_read_pointer_q <= fifo_read_pointer_q + 5'h01;
      end
   end

   // two-flop synchronisers, third sck stage only for edge finding
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_s_q   <= 3'h0;
         ss_s_q    <= 2'h3;
         mosi_s_q  <= 2'h0;
         ss_prev_q <= 1'b1;
      end else begin
         sck_s_q   <= {sck_s_q[1:0], sck};
         ss_s_q    <= {ss_s_q[0], ss_n};
         mosi_s_q  <= {mosi_s_q[0], mosi};
         ss_prev_q <= ss_s_q[1];
      end
   end

   // mode 0 shifter: sample on rising sck, advance on falling sck, msb first
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_shift_q       <= 8'h00;
         rx_shift_q       <= 8'h00;
         bit_cnt_q        <= 4'h0;
         shifter_loaded_q <= 1'b0;
         miso_q           <= 1'b0;
      end else if (!module_on || !sel) begin
         bit_cnt_q        <= 4'h0;
         shifter_loaded_q <= 1'b0;
         miso_q           <= 1'b0;
      end else begin
         if (load_now) begin
            // empty buffer sends zeros
            tx_shift_q       <= tx_empty ? 8'h00 : tx_mem[tx_rd_q[3:0]];
            miso_q           <= tx_empty ? 1'b0 : tx_mem[tx_rd_q[3:0]][7];
            shifter_loaded_q <= ~tx_empty;
         end else if (sck_fall && bit_cnt_q != 4'h0) begin
            tx_shift_q <= {tx_shift_q[6:0], 1'b0};
            miso_q     <= tx_shift_q[6];
         end
         if (sck_rise) begin
            rx_shift_q <= rx_next;
            bit_cnt_q  <= word_done ? 4'h0 : bit_cnt_q + 4'h1;
         end
      end
   end

endmodule // spi_status_flags

// ==== tb/spi_status_flags_properties.sv ====
// apb-side properties of the serial link status block
// assumes the design's register map header; bound to the top module
`timescale 1ns/1ps
`include "spi_status_flags_defs.vh"
module spi_status_flags_properties (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata_q,
   input wire logic        pready_q,
   input wire logic        pslverr_q
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // shadow of control so gated fields can be judged
   logic [2:0] ctl_q;
   wire        st_rd = pready_q && !pwrite && paddr == `OFS_STATUS;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ctl_q <= 3'h0;
      else if (pready_q && pwrite && paddr == `OFS_CONTROL)
         ctl_q <= pwdata[2:0];
   end
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable;
   endsequence
   chk_ready_timing: assert property (setup_s ##1 access_s |-> !pready_q ##1 pready_q)
      else $error("ready not after one wait state");
   chk_ready_pulse: assert property (pready_q |=> !pready_q)
      else $error("ready longer than one cycle");
   chk_err_map: assert property (pready_q |-> pslverr_q == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}))
      else $error("error response wrong for address");
   chk_idle_zero: assert property (!pready_q |-> prdata_q == 32'h0)
      else $error("read data outside completion");
   chk_unused_zero: assert property (st_rd |-> (prdata_q & 32'he0e0_e610) == 32'h0)
      else $error("unimplemented status bit set");
   chk_fill_gated: assert property (st_rd && !ctl_q[1] |-> prdata_q[28:24] == 5'h0 && prdata_q[20:16] == 5'h0)
      else $error("fill count shown without enhanced buffering");
   chk_flag_gated: assert property (st_rd && !ctl_q[1] |-> !prdata_q[7] && !prdata_q[5])
      else $error("shifter or rx empty shown without enhanced buffering");
   chk_rx_empty: assert property (st_rd && ctl_q[1] |-> prdata_q[5] == (prdata_q[28:24] == 5'h0))
      else $error("rx empty disagrees with rx count");
   chk_tx_empty: assert property (st_rd && ctl_q[1] |-> prdata_q[3] == (prdata_q[20:16] == 5'h0))
      else $error("tx empty disagrees with tx count");
   chk_busy_off: assert property (st_rd && !ctl_q[0] |-> !prdata_q[11])
      else $error("busy while module off");
endmodule // spi_status_flags_properties

bind spi_status_flags spi_status_flags_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
   .pready_q(pready_q), .pslverr_q(pslverr_q));

// ==== tb/spi_ctl_model.sv ====
// behavioural serial controller on the link, mode 0, msb first
// assumes the device oversamples sck with its own clock; 80 ns sck period
`timescale 1ns/1ps
module spi_ctl_model (
   // link
   output logic      sck,
   output logic      ss_n,
   output logic      mosi,
   input  wire logic miso_q
);
   initial begin
      sck = 1'b0;
      ss_n = 1'b1;
      mosi = 1'b0;
   end
   // fewer than 8 bits cuts the word short on purpose
   task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
      rx = 8'h00;
      ss_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         mosi = tx[7-i];
         #40;
         rx = {rx[6:0], miso_q};
         sck = 1'b1;
         #40;
         sck = 1'b0;
      end
      #120;
      ss_n = 1'b1;
      // released line must not keep showing the last bit
      mosi = ~mosi;
      #200;
   endtask
endmodule // spi_ctl_model

// ==== tb/tb_spi_status_flags.sv ====
// self-checking bench for the serial link status block over apb
// assumes the behavioural controller model on the link side
`timescale 1ns/1ps
`include "spi_status_flags_defs.vh"
module tb_spi_status_flags;
   logic        pclk, presetn, psel, penable, pwrite, err;
   logic [7:0]  paddr, rx;
   logic [31:0] pwdata, rd;
   wire  [31:0] prdata_q;
   wire         pready_q, pslverr_q, sck, ss_n, mosi, miso_q, irq_q;
   int          miscompares = 0;
   int          n_tests = 0;

   spi_status_flags dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
      .sck(sck), .ss_n(ss_n), .mosi(mosi), .miso_q(miso_q), .irq_q(irq_q));
   spi_ctl_model ctl (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso_q(miso_q));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no own limit: only the watchdog ends a wait that never completes
      do begin
         @(posedge pclk);
      end while (pready_q !== 1'b1);
      rd = prdata_q;
      err = pslverr_q;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
      n_tests++;
      if ((got & m) !== (exp & m)) begin
         miscompares++;
         $display("MISMATCH at %0t: got %h expected %h mask %h", $time, got, exp, m);
      end
   endtask
   task automatic chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      apb(1'b0, a, 32'h0);
      cmp(rd, exp, m);
   endtask
   task stop_test;
      $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      #500000;
      miscompares++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      stop_test;
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(`OFS_STATUS, 32'h0000_0008, 32'hffff_ffff);
      apb(1'b0, 8'h20, 32'h0);
      cmp({31'h0, err}, 32'h1, 32'h1);
      cmp(rd, 32'h0, 32'hffff_ffff);
      wr(`OFS_INT_MASK, 32'h1);
      wr(`OFS_CONTROL, 32'h3);
      chk(`OFS_STATUS, 32'h0000_00a8, 32'hffff_ffff);
      wr(`OFS_DATA, 32'ha1);
      wr(`OFS_DATA, 32'hb2);
      wr(`OFS_DATA, 32'hc3);
      chk(`OFS_STATUS, 32'h0003_08a0, 32'hffff_ffff);
      // status read in mid-frame: shifter holds a word, link busy
      fork
         ctl.xfer(8'h5a, 8, rx);
         begin
            repeat (20) @(posedge pclk);
            chk(`OFS_STATUS, 32'h0002_0800, 32'h001f_0880);
         end
      join
      cmp({24'h0, rx}, 32'ha1, 32'hff);
      cmp({31'h0, irq_q}, 32'h1, 32'h1);
      chk(`OFS_STATUS, 32'h0100_0000, 32'h1f00_0020);
      chk(`OFS_INT_STATUS, 32'h1, 32'hf);
      @(posedge pclk);
      cmp({31'h0, irq_q}, 32'h0, 32'h1);
      chk(`OFS_DATA, 32'h5a, 32'hff);
      // legacy depth of one makes overflow cheap to reach
      wr(`OFS_CONTROL, 32'h0);
      wr(`OFS_CONTROL, 32'h1);
      ctl.xfer(8'h11, 8, rx);
      ctl.xfer(8'h22, 8, rx);
      chk(`OFS_STATUS, 32'h40, 32'h40);
      wr(`OFS_STATUS, 32'hffff_ffff);
      chk(`OFS_STATUS, 32'h40, 32'h40);
      chk(`OFS_DATA, 32'h11, 32'hff);
      wr(`OFS_STATUS, 32'h0);
      chk(`OFS_STATUS, 32'h0, 32'h40);
      ctl.xfer(8'h33, 8, rx);
      ctl.xfer(8'h44, 8, rx);
      chk(`OFS_STATUS, 32'h40, 32'h40);
      wr(`OFS_CONTROL, 32'h0);
      wr(`OFS_CONTROL, 32'h1);
      chk(`OFS_STATUS, 32'h0, 32'h40);
      // framed with nothing queued forces underrun at every load
      wr(`OFS_CONTROL, 32'h5);
      ctl.xfer(8'h55, 8, rx);
      chk(`OFS_STATUS, 32'h100, 32'h1100);
      wr(`OFS_STATUS, 32'hffff_ffff);
      chk(`OFS_STATUS, 32'h100, 32'h100);
      wr(`OFS_STATUS, 32'h0);
      chk(`OFS_STATUS, 32'h0, 32'h100);
      ctl.xfer(8'h66, 4, rx);
      chk(`OFS_STATUS, 32'h1100, 32'h1100);
      wr(`OFS_STATUS, 32'hffff_feff);
      chk(`OFS_STATUS, 32'h1000, 32'h1100);
      wr(`OFS_STATUS, 32'h0);
      chk(`OFS_STATUS, 32'h0, 32'h1000);
      ctl.xfer(8'h77, 8, rx);
      chk(`OFS_STATUS, 32'h100, 32'h100);
      wr(`OFS_CONTROL, 32'h0);
      wr(`OFS_CONTROL, 32'h5);
      chk(`OFS_STATUS, 32'h0, 32'h100);
      stop_test;
   end
endmodule // tb_spi_status_flags
